// *** maint_disable_ctrl.sv ***
// Maintenance-disable controller: button timing, indicator flash and report gating.
`timescale 1ns/1ps
module maint_disable_ctrl
  import maint_disable_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_CYCLES = CNT_W'(ENTRY_HOLD_CYCLES),
  parameter logic [CNT_W-1:0] HALF_FLASH_CYCLES = CNT_W'(FLASH_HALF_CYCLES),
  parameter logic [CNT_W-1:0] DEFAULT_TIMEOUT = CNT_W'(TIMEOUT_CYCLES),
  parameter int unsigned SETTLE_CYCLES = DEBOUNCE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic btn_raw,
  input wire logic [CNT_W-1:0] timeout_cycles,
  input wire logic logic_ok,
  input wire logic status_change,
  input wire logic fault_pending,
  output logic report_req,
  output logic report_outstanding,
  output logic clear_faults,
  output logic maint_active,
  output logic logic_led
);

  logic btn;

  // Synchronised and debounced button level.
  button_debounce #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_deb (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .btn_raw(btn_raw),
    .btn_level(btn)
  );

  typedef struct packed {
    mode_state_t st;
    logic btn_d;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] mode_cnt;
    logic [CNT_W-1:0] flash_cnt;
    logic flash;
    logic rep;
    logic outst;
    logic clr;
    logic led;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;
  logic press_end;
  logic [CNT_W-1:0] tmo;

  assign press_end = s_reg.btn_d && !btn;
  assign tmo = (timeout_cycles == CNT_ZERO) ? DEFAULT_TIMEOUT : timeout_cycles;

  always_comb begin
    s_next = s_reg;
    s_next.btn_d = btn;
    s_next.rep = 1'b0;
    s_next.outst = 1'b0;
    s_next.clr = 1'b0;
    s_next.hold_cnt = btn ? s_reg.hold_cnt + CNT_ONE : CNT_ZERO;
    case (s_reg.st)
      ST_NORMAL: begin
        s_next.flash = 1'b0;
        s_next.flash_cnt = CNT_ZERO;
        s_next.rep = status_change;
        if (btn && s_reg.hold_cnt == HOLD_CYCLES - CNT_ONE) begin
          s_next.st = ST_WAIT_REL;
          s_next.mode_cnt = CNT_ZERO;
          s_next.flash = 1'b1;
        end else if (press_end) begin
          s_next.clr = 1'b1;
        end
      end
      ST_WAIT_REL, ST_DISABLED: begin
        s_next.mode_cnt = s_reg.mode_cnt + CNT_ONE;
        if (s_reg.flash_cnt == HALF_FLASH_CYCLES - CNT_ONE) begin
          s_next.flash_cnt = CNT_ZERO;
          s_next.flash = !s_reg.flash;
        end else begin
          s_next.flash_cnt = s_reg.flash_cnt + CNT_ONE;
        end
        if (s_reg.st == ST_WAIT_REL && !btn) begin
          s_next.st = ST_DISABLED;
        end
        if (s_reg.mode_cnt >= tmo - CNT_ONE ||
            (s_reg.st == ST_DISABLED && press_end)) begin
          s_next.st = ST_NORMAL;
          s_next.flash = 1'b0;
          s_next.outst = fault_pending;
          s_next.rep = fault_pending;
          s_next.clr = press_end;
        end
      end
      default: begin
        s_next.st = ST_NORMAL;
      end
    endcase
    // The indicator is registered so that no input glitch reaches the lamp driver.
    s_next.led = (s_next.st != ST_NORMAL) ? s_next.flash : logic_ok;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '{st: ST_NORMAL, default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign maint_active = s_reg.st != ST_NORMAL;
  assign logic_led = s_reg.led;
  assign report_req = s_reg.rep;
  assign report_outstanding = s_reg.outst;
  assign clear_faults = s_reg.clr;

  // Helper: reports blocked in mode.
  no_report_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    maint_active && ce && !(s_reg.mode_cnt >= tmo - CNT_ONE) |=> !report_req || report_outstanding)
    else $error("status report sent during maintenance disable");

  enter_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && !maint_active && btn && s_reg.hold_cnt == HOLD_CYCLES - CNT_ONE |=> maint_active)
    else $error("mode not entered after full hold");

  no_early_entry_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(maint_active) |-> $past(s_reg.hold_cnt) == HOLD_CYCLES - CNT_ONE)
    else $error("mode entered before hold time");

  press_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && s_reg.st == ST_DISABLED && press_end |=> !maint_active && clear_faults)
    else $error("brief press did not end mode");

  timeout_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && maint_active && s_reg.mode_cnt >= tmo - CNT_ONE |=> !maint_active)
    else $error("timeout did not end mode");

  exit_report_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && maint_active && fault_pending && s_reg.mode_cnt >= tmo - CNT_ONE
    |=> report_req && report_outstanding)
    else $error("pending faults not reported on exit");

  flash_toggle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && maint_active && s_reg.flash_cnt == HALF_FLASH_CYCLES - CNT_ONE
    && !(s_reg.mode_cnt >= tmo - CNT_ONE) && !press_end |=> s_reg.flash != $past(s_reg.flash))
    else $error("indicator did not toggle at half period");

  bounded_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    maint_active |-> s_reg.mode_cnt < tmo)
    else $error("suppression exceeded timeout");

  clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && s_reg.st == ST_NORMAL && press_end && !btn |=> clear_faults)
    else $error("press did not clear faults");

  report_pass_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && s_reg.st == ST_NORMAL && status_change |=> report_req)
    else $error("status change not reported in normal mode");

  wait_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && s_reg.st == ST_WAIT_REL && !(s_reg.mode_cnt >= tmo - CNT_ONE) |=> maint_active)
    else $error("release of entry hold ended the mode");

  entry_flash_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(maint_active) |-> logic_led)
    else $error("indicator not lit at mode entry");

  led_normal_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && s_next.st == ST_NORMAL |=> logic_led == $past(logic_ok))
    else $error("indicator does not follow logic level");

  flash_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && maint_active && s_reg.flash_cnt != HALF_FLASH_CYCLES - CNT_ONE
    && !(s_reg.mode_cnt >= tmo - CNT_ONE) && !press_end |=> $stable(s_reg.flash))
    else $error("indicator changed before half period");

  clear_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(clear_faults) |-> $past(press_end))
    else $error("faults cleared without a press");

  outst_pair_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    report_outstanding |-> report_req)
    else $error("exit report without report request");

  outst_exit_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(report_outstanding) |-> $fell(maint_active))
    else $error("exit report outside mode exit");

  hold_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && !btn |=> s_reg.hold_cnt == CNT_ZERO)
    else $error("hold count kept after release");

  // A low clock enable must also hold the timeout count still.
  state_freeze_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ce |=> $stable(s_reg))
    else $error("state moved while clock enable low");

  enter_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(maint_active));
  press_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    s_reg.st == ST_DISABLED && press_end);
  timeout_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    $fell(maint_active) && report_outstanding);
  release_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    s_reg.st == ST_WAIT_REL && !btn);
  freeze_c: cover property (@(posedge clk_sys) disable iff (!rstn) maint_active && !ce);

endmodule

// *** maint_disable_pkg.sv ***
// Shared constants and types for the maintenance-disable controller.
package maint_disable_pkg;

  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Debounce settle time and its cycle count.
  localparam int unsigned DEBOUNCE_US = 10;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;

  // Hold time for mode entry.
  localparam int unsigned ENTRY_HOLD_S = 5;
  localparam longint unsigned ENTRY_HOLD_CYCLES = 64'(ENTRY_HOLD_S) * CLK_HZ;

  // Flash period of the logic indicator: one flash each second.
  localparam int unsigned FLASH_PERIOD_MS = 1000;
  localparam longint unsigned FLASH_HALF_CYCLES = 64'(FLASH_PERIOD_MS) * CLK_HZ / 2000;

  // Default automatic timeout in minutes.
  localparam int unsigned TIMEOUT_MIN = 45;
  localparam longint unsigned TIMEOUT_CYCLES = 64'(TIMEOUT_MIN) * 60 * CLK_HZ;

  localparam int CNT_W = 40;
  localparam logic [CNT_W-1:0] CNT_ZERO = 40'h00_0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 40'h00_0000_0001;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'h1,
    ST_DISABLED = 3'h2,
    ST_WAIT_REL = 3'h4
  } mode_state_t;

endpackage

// *** button_debounce.sv ***
// Two-flop synchroniser and debounce filter for the fault-clear button.
`timescale 1ns/1ps
module button_debounce
  import maint_disable_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = DEBOUNCE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic btn_raw,
  output logic btn_level
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic stable;
    logic [19:0] cnt;
  } deb_state_t;

  deb_state_t s_reg;
  deb_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.sync1 = btn_raw;
    s_next.sync2 = s_reg.sync1;
    if (s_reg.sync2 == s_reg.stable) begin
      s_next.cnt = 20'h00000;
    end else if (s_reg.cnt >= 20'(SETTLE_CYCLES - 1)) begin
      s_next.stable = s_reg.sync2;
      s_next.cnt = 20'h00000;
    end else begin
      s_next.cnt = s_reg.cnt + 20'h00001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign btn_level = s_reg.stable;

endmodule

// *** panel_model.sv ***
// Model of the fault-clear button and the control centre reporting link.
`timescale 1ns/1ps
module panel_model (
  input wire logic clk_sys,
  input wire logic report_req,
  input wire logic report_outstanding,
  output logic btn_raw
);
  int reports = 0;
  int outstanding = 0;
  initial btn_raw = 1'b0;
  // Contacts bounce for a few cycles on press and on release.
  task automatic press(input int hold);
    repeat (3) begin
      @(posedge clk_sys);
      #1 btn_raw = ~btn_raw;
    end
    repeat (hold) @(posedge clk_sys);
    repeat (3) begin
      #1 btn_raw = ~btn_raw;
      @(posedge clk_sys);
    end
  endtask
  always @(posedge clk_sys) begin
    if (report_req === 1'b1) reports++;
    if (report_outstanding === 1'b1) outstanding++;
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the maintenance-disable controller.
`timescale 1ns/1ps
module testbench;
  import maint_disable_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic logic_ok = 1'b0;
  logic status_change = 1'b0;
  logic fault_pending = 1'b0;
  logic btn_raw;
  logic [CNT_W-1:0] timeout_cycles = CNT_ZERO;
  logic report_req, report_outstanding, clear_faults, maint_active, logic_led;
  int mismatches = 0;
  int check_count = 0;
  int seed = 89690;
  int clears = 0;
  int n, sent, c;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (clear_faults === 1'b1) clears++;
  panel_model panel (.clk_sys(clk_sys), .report_req(report_req),
    .report_outstanding(report_outstanding), .btn_raw(btn_raw));
  maint_disable_ctrl #(.HOLD_CYCLES(40'h32), .HALF_FLASH_CYCLES(40'h8),
    .DEFAULT_TIMEOUT(40'hC8), .SETTLE_CYCLES(2)) dut (.clk_sys(clk_sys), .rstn(rstn),
    .ce(ce), .btn_raw(btn_raw), .timeout_cycles(timeout_cycles), .logic_ok(logic_ok),
    .status_change(status_change), .fault_pending(fault_pending), .report_req(report_req),
    .report_outstanding(report_outstanding), .clear_faults(clear_faults),
    .maint_active(maint_active), .logic_led(logic_led));
  function automatic int exp_tmo(input logic [CNT_W-1:0] t);
    return (t == CNT_ZERO) ? 200 : int'(t);
  endfunction
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_mode(input logic val, input int bound);
    n = 0;
    while (maint_active !== val && n < bound) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check("mode wait", 40'h1, 40'(n < bound));
    if (n == bound) stop_test();
  endtask
  task automatic run_len();
    logic v;
    v = logic_led;
    n = 0;
    while (logic_led === v && n < 40) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  task automatic pulse_status();
    @(posedge clk_sys);
    #1 status_change = 1'b1;
    @(posedge clk_sys);
    #1 status_change = 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'b1;
    for (int i = 0; i < 20; i++) begin
      logic_ok = 1'($random(seed));
      sent = panel.reports;
      pulse_status();
      check("led follows ok", 40'(logic_ok), 40'(logic_led));
      repeat (1 + ($random(seed) & 3)) @(posedge clk_sys);
      #1 check("report count", 40'(sent + 1), 40'(panel.reports));
    end
    c = clears;
    panel.press(10);
    repeat (12) @(posedge clk_sys);
    #1 check("press clears", 40'(c + 1), 40'(clears));
    check("no entry", 40'h0, 40'(maint_active));
    fork
      panel.press(80);
      wait_mode(1'b1, 80);
    join_any
    check("held at entry", 40'h1, 40'(btn_raw));
    run_len();
    run_len();
    check("flash half", 40'h8, 40'(n));
    sent = panel.reports;
    repeat (3) pulse_status();
    wait fork;
    #1 check("suppressed", 40'(sent), 40'(panel.reports));
    check("release kept", 40'h1, 40'(maint_active));
    fault_pending = 1'b1;
    c = clears;
    sent = panel.outstanding;
    fork
      panel.press(10);
      wait_mode(1'b0, 40);
    join
    @(posedge clk_sys);
    #1 check("exit clears", 40'(c + 1), 40'(clears));
    check("exit report", 40'(sent + 1), 40'(panel.outstanding));
    for (int i = 0; i < 2; i++) begin
      timeout_cycles = i ? CNT_ZERO : 40'h64;
      fault_pending = ~fault_pending;
      fork
        panel.press(80);
        wait_mode(1'b1, 80);
      join_any
      sent = panel.outstanding;
      // Five frozen edges must push the exit back by five.
      ce = 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 ce = 1'b1;
      wait_mode(1'b0, 300);
      n = n - exp_tmo(timeout_cycles);
      check("timeout length", 40'h1, 40'(n >= -2 && n <= 2));
      wait fork;
      @(posedge clk_sys);
      #1 check("timeout report", 40'(sent + fault_pending), 40'(panel.outstanding));
    end
    stop_test();
  end
endmodule
